// ==== hw/pfs_pkg.sv ====
// constants for the pin function select block, select registers 17 to 19
package pfs_pkg;
    localparam int NUM_REGS = 3;
    localparam int NUM_PINS = 24;
    localparam int NUM_SLOTS = 5;
    localparam int FIELD_W = 4;

    // byte offsets of the select registers on the register bus
    localparam logic [7:0] OFF_SEL17 = 8'h00;
    localparam logic [7:0] OFF_SEL18 = 8'h04;
    localparam logic [7:0] OFF_SEL19 = 8'h08;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;

    // field codes that pick a function; every other code is reserved
    localparam logic [3:0] CODE_S0 = 4'h0;
    localparam logic [3:0] CODE_S1 = 4'h1;
    localparam logic [3:0] CODE_S2 = 4'h2;
    localparam logic [3:0] CODE_S3 = 4'h4;
    localparam logic [3:0] CODE_S4 = 4'h8;

    // pin types: none (hi-z or reserved), input, output, bidirectional
    localparam logic [1:0] PT_NO = 2'h0;
    localparam logic [1:0] PT_IN = 2'h1;
    localparam logic [1:0] PT_OUT = 2'h2;
    localparam logic [1:0] PT_BI = 2'h3;

    // pin index that carries the debug return clock on both code 0 and 1h
    localparam int DBG_CLK_PIN = 23;

    // per-pin type rows, slot 4 leftmost; pin p = reg * 8 + field (field 0 = bits 3-0)
    localparam logic [9:0] ROW_STRAP = {PT_BI, PT_BI, PT_BI, PT_OUT, PT_IN};
    localparam logic [9:0] ROW_R18_F7 = {PT_BI, PT_OUT, PT_OUT, PT_BI, PT_IN};
    localparam logic [9:0] ROW_R18_F6 = {PT_BI, PT_OUT, PT_OUT, PT_BI, PT_NO};
    localparam logic [9:0] ROW_R18_F5 = {PT_BI, PT_BI, PT_OUT, PT_OUT, PT_IN};
    localparam logic [9:0] ROW_R18_F4 = {PT_BI, PT_BI, PT_BI, PT_OUT, PT_IN};
    localparam logic [9:0] ROW_R18_F3 = {PT_BI, PT_BI, PT_OUT, PT_OUT, PT_IN};
    localparam logic [9:0] ROW_R19_F7 = {PT_BI, PT_NO, PT_NO, PT_OUT, PT_OUT};
    localparam logic [9:0] ROW_R19_F6 = {PT_BI, PT_NO, PT_OUT, PT_NO, PT_IN};
    localparam logic [9:0] ROW_R19_F5 = {PT_BI, PT_OUT, PT_NO, PT_OUT, PT_IN};
    localparam logic [9:0] ROW_R19_CKI = {PT_BI, PT_OUT, PT_BI, PT_IN, PT_IN};
    localparam logic [9:0] ROW_R19_CKO = {PT_BI, PT_OUT, PT_BI, PT_OUT, PT_IN};
    localparam logic [9:0] ROW_R19_SYN = {PT_BI, PT_OUT, PT_OUT, PT_BI, PT_IN};

    // pin 23 leftmost, pin 0 rightmost
    localparam logic [239:0] PIN_TYPE = {
        ROW_R19_F7, ROW_R19_F6, ROW_R19_F5, ROW_R19_CKI,
        ROW_R19_CKO, ROW_R19_CKI, ROW_R19_SYN, ROW_R19_SYN,
        ROW_R18_F7, ROW_R18_F6, ROW_R18_F5, ROW_R18_F4,
        ROW_R18_F3, ROW_R18_F4, ROW_STRAP, ROW_STRAP,
        ROW_STRAP, ROW_STRAP, ROW_STRAP, ROW_STRAP,
        ROW_STRAP, ROW_STRAP, ROW_STRAP, ROW_STRAP};

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : pfs_pkg

// ==== hw/pfs_pin_select.sv ====
// pin function select for select registers 17 to 19, AXI4-Lite slave
`timescale 1ns/100ps

// Function
// - three 32-bit registers, eight 4-bit fields, reset 0
// - reg17 upper six fields: strap/video/display/parport/gpio7
// - reg17 bits 27-24: strap in, parport bidirectional
// - reg18 low fields: strap/video/display/parport/gpio7
// - reg17 low fields: rt-unit input, video, display...
// - reserved codes undefined; function type sets direction
// - reg18 bits 27-24: code 0 high impedance
// - reg18 bits 31-28: rt input, card, master clock
// - reg18 bits 23-20: rt, parport b wait, gpio8
// - reg18 bits 19-16: card command, parport b enable
// - reg18 bits 15-12: card clock output, parport start
// - reg18 bits 11-8: card data 0, parport clock
// - reg19 bits 31-28: codes 0,1h debug clock
// - reg19 bits 27-24: rt input, ac-bias, gpio6
// - reg19 bits 23-20: video clock out three
// - reg19 19-16, 11-8: video clock inputs, card data
// - reg19 bits 15-12: video clock out two
// - reg19 bits 7-4: card data 4, vertical sync
// - reg19 bits 3-0: card data 5, horizontal sync
module pfs_pin_select
    import pfs_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_PINS*NUM_SLOTS-1:0] periph_out,
    input wire logic [NUM_PINS*NUM_SLOTS-1:0] periph_oe,
    output logic [NUM_PINS*NUM_SLOTS-1:0] periph_in,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe
);
    logic [31:0] sel_r [NUM_REGS];
    logic [31:0] sel_nxt [NUM_REGS];
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [NUM_PINS-1:0] pin_meta_r;
    logic [NUM_PINS-1:0] pin_sync_r;
    logic [NUM_PINS-1:0] pin_out_r;
    logic [NUM_PINS-1:0] pin_oe_r;
    logic [NUM_PINS*NUM_SLOTS-1:0] periph_in_r;
    logic [NUM_PINS-1:0] out_nxt;
    logic [NUM_PINS-1:0] oe_nxt;
    logic [NUM_PINS*NUM_SLOTS-1:0] in_nxt;

    // write side: address and data are caught in either order
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire wr_go = !awready_r && !wready_r && !bvalid_r;
    wire b_done = bvalid_r && s_axi_bready;
    wire [ADDR_W-1:0] aw_word = {aw_addr_r[ADDR_W-1:2], 2'b00};
    wire [1:0] wr_idx = (aw_word == ADDR_W'(OFF_SEL17)) ? 2'd0 :
                        (aw_word == ADDR_W'(OFF_SEL18)) ? 2'd1 :
                        (aw_word == ADDR_W'(OFF_SEL19)) ? 2'd2 : 2'd3;
    wire wr_map = (wr_idx != 2'd3);

    // read side
    wire ar_take = s_axi_arvalid && arready_r;
    wire r_done = rvalid_r && s_axi_rready;
    wire [ADDR_W-1:0] ar_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire rd_map17 = (ar_word == ADDR_W'(OFF_SEL17));
    wire rd_map18 = (ar_word == ADDR_W'(OFF_SEL18));
    wire rd_map19 = (ar_word == ADDR_W'(OFF_SEL19));
    wire rd_map = rd_map17 || rd_map18 || rd_map19;
    wire [31:0] rd_val = rd_map17 ? sel_r[0] :
                         rd_map18 ? sel_r[1] :
                         rd_map19 ? sel_r[2] : 32'h0000_0000;

    genvar r, b, p, s;
    // byte-lane writes into the select registers
    for (r = 0; r < NUM_REGS; r++)
    begin : g_reg
        for (b = 0; b < 4; b++)
        begin : g_byte
            wire lane_wr = wr_go && (wr_idx == 2'(r)) && w_strb_r[b];
            assign sel_nxt[r][b*8 +: 8] = lane_wr ? w_data_r[b*8 +: 8] : sel_r[r][b*8 +: 8];
        end
    end

    // per-pin routing; a field's code picks one of five slots
    for (p = 0; p < NUM_PINS; p++)
    begin : g_pin
        wire [3:0] code = sel_r[p/8][(p%8)*FIELD_W +: FIELD_W];
        wire [9:0] types = PIN_TYPE[p*10 +: 10];
        // reserved codes hit no slot: pin released, nothing routed in
        wire [4:0] hit = {code == CODE_S4, code == CODE_S3, code == CODE_S2,
                          code == CODE_S1, code == CODE_S0};
        wire [4:0] sel_o;
        wire [4:0] drv_o;
        wire [4:0] drv_b;
        wire [4:0] sel_e;
        for (s = 0; s < NUM_SLOTS; s++)
        begin : g_slot
            // debug return clock pin: code 1h reuses the code 0 source
            localparam int SRC = (p == DBG_CLK_PIN && s == 1) ? 0 : s;
            wire [1:0] t = types[s*2 +: 2];
            // reserved and high-impedance slots hold the drive value low too
            assign sel_o[s] = hit[s] && (t != PT_NO) && periph_out[p*NUM_SLOTS+SRC];
            assign sel_e[s] = periph_oe[p*NUM_SLOTS+SRC];
            assign drv_o[s] = hit[s] && (t == PT_OUT);
            assign drv_b[s] = hit[s] && (t == PT_BI) && sel_e[s];
            assign in_nxt[p*NUM_SLOTS+s] = hit[s] && (t == PT_IN || t == PT_BI) && pin_sync_r[p];
        end
        // types of each pin follow the mapping table in the package
        assign out_nxt[p] = |sel_o;
        assign oe_nxt[p] = (|drv_o) || (|drv_b);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                sel_r[i] <= SEL_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // ready drops once a channel is caught and returns once the response is accepted
    wire awready_nxt = b_done ? 1'b1 : (aw_take ? 1'b0 : awready_r);
    wire wready_nxt = b_done ? 1'b1 : (w_take ? 1'b0 : wready_r);
    wire bvalid_nxt = wr_go ? 1'b1 : (b_done ? 1'b0 : bvalid_r);
    wire [1:0] bresp_nxt = wr_go ? (wr_map ? RESP_OKAY : RESP_DECERR) : bresp_r;
    // read answer latched at the take, so a later write cannot disturb it
    wire arready_nxt = ar_take ? 1'b0 : (r_done ? 1'b1 : arready_r);
    wire rvalid_nxt = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_r);
    wire [31:0] rdata_nxt = ar_take ? rd_val : rdata_r;
    wire [1:0] rresp_nxt = ar_take ? (rd_map ? RESP_OKAY : RESP_DECERR) : rresp_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            awready_r <= 1'b1;
        end
        else
        begin
            awready_r <= awready_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wready_r <= 1'b1;
        end
        else
        begin
            wready_r <= wready_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
        end
        else
        begin
            bvalid_r <= bvalid_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            bresp_r <= bresp_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            arready_r <= 1'b1;
        end
        else
        begin
            arready_r <= arready_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= rvalid_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            rresp_r <= rresp_nxt;
        end
    end

    // pins are asynchronous to core_clk: two flops before routing
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // registered pin side costs a cycle but keeps outputs glitch-free
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_out_r <= '0;
        end
        else
        begin
            pin_out_r <= out_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_oe_r <= '0;
        end
        else
        begin
            pin_oe_r <= oe_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            periph_in_r <= '0;
        end
        else
        begin
            periph_in_r <= in_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign periph_in = periph_in_r;
endmodule : pfs_pin_select

// ==== tb/pfs_partner.sv ====
// far-side model: external pin drivers and peripheral signal sources
`timescale 1ns/100ps
module pfs_partner (
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe,
    input wire logic [23:0] ext_lvl,
    output logic [23:0] pin_in,
    output logic [119:0] periph_out
);
    // the outside device drives a pin only once the block has let it go
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    // odd slots high, even slots low, so a wrong slot choice shows on the pin
    assign periph_out = {24{5'b01010}};
endmodule : pfs_partner

// ==== tb/pfs_properties.sv ====
// register bus handshake assertions for the pin function select block
`timescale 1ns/100ps
module pfs_properties
    import pfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
    sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
    property p_aw_block; s_aw |=> !s_axi_awready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("awready high after take");
    property p_w_block; s_w |=> !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block) else $error("wready high after take");
    property p_b_answer; s_aw ##0 s_w |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_answer: assert property (p_b_answer) else $error("no write response");
    property p_b_clear; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] s_axi_awready; endproperty
    a_b_clear: assert property (p_b_clear) else $error("write not closed");
    property p_r_answer; s_ar |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("no read data");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("arready during read answer");
    property p_r_err; s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0000_0000; endproperty
    a_r_err: assert property (p_r_err) else $error("error read with data");
endmodule : pfs_properties

bind pfs_pin_select pfs_properties u_props (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tb/testbench.sv ====
// self-checking bench for the pin function select block
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench
    import pfs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0000_0000, rdata, q;
    logic [1:0] bresp, rresp, r;
    logic [119:0] periph_out, periph_in, periph_oe = {120{1'b1}};
    logic [23:0] pin_in, pin_out, pin_oe, ext_lvl = 24'hff_ffff;
    logic [3:0] wstrb = 4'hf, cd;
    logic exp_out;
    int failures = 0, checked = 0, cyc = 0;
    // address, data, pin, expected drive
    logic [45:0] rows [22] = '{
        {8'h00, 32'h0000_0000, 5'h07, 1'b0}, {8'h00, 32'h1000_0000, 5'h07, 1'b1},
        {8'h00, 32'h0400_0000, 5'h06, 1'b1}, {8'h00, 32'h0000_0008, 5'h00, 1'b1},
        {8'h00, 32'h0000_0003, 5'h00, 1'b0}, {8'h04, 32'h0000_0020, 5'h09, 1'b1},
        {8'h04, 32'h0000_0000, 5'h0e, 1'b0}, {8'h04, 32'h0200_0000, 5'h0e, 1'b1},
        {8'h04, 32'h2000_0000, 5'h0f, 1'b1}, {8'h04, 32'h0040_0000, 5'h0d, 1'b1},
        {8'h04, 32'h0002_0000, 5'h0c, 1'b1}, {8'h04, 32'h0000_1000, 5'h0b, 1'b1},
        {8'h04, 32'h0000_0400, 5'h0a, 1'b1}, {8'h08, 32'h0000_0000, 5'h17, 1'b1},
        {8'h08, 32'h1000_0000, 5'h17, 1'b1}, {8'h08, 32'h2000_0000, 5'h17, 1'b0},
        {8'h08, 32'h0100_0000, 5'h16, 1'b0}, {8'h08, 32'h0020_0000, 5'h15, 1'b0},
        {8'h08, 32'h0001_0000, 5'h14, 1'b0}, {8'h08, 32'h0000_1000, 5'h13, 1'b1},
        {8'h08, 32'h0000_0020, 5'h11, 1'b1}, {8'h08, 32'h0000_0002, 5'h10, 1'b1}};

    always #5 core_clk = ~core_clk;

    pfs_pin_select uut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pfs_partner u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in),
        .periph_out(periph_out));

    task give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge core_clk);
            ad = ad | (awready === 1'b1);
            dd = dd | (wready === 1'b1);
            if (ad) awvalid <= 1'b0;
            if (dd) wvalid <= 1'b0;
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    // lag holds rready low for a while to stretch the answer
    task rd(input logic [7:0] a, input int lag);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat (lag) @(posedge core_clk);
        rready <= 1'b1;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        q = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            give_verdict;
        end
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd(OFF_SEL17 + 8'(4 * i), 0);
            `CHK("reset value", SEL_RESET, q)
        end
        `CHK("strap input", 1'b1, periph_in[35])
        `CHK("unselected slot", 1'b0, periph_in[36])
        rd(8'h0c, 3);
        `CHK("unmapped rresp", RESP_DECERR, r)
        wr(8'h0c, 32'hffff_ffff);
        `CHK("unmapped bresp", RESP_DECERR, r)
        foreach (rows[i])
        begin
            wr(rows[i][45:38], rows[i][37:6]);
            `CHK("bresp", RESP_OKAY, r)
            rd(rows[i][45:38], i % 2);
            `CHK("readback", rows[i][37:6], q)
            #1;
            `CHK("pin_oe", rows[i][0], pin_oe[rows[i][5:1]])
            cd = 4'(rows[i][37:6] >> (4 * (rows[i][5:1] % 8)));
            // odd slots carry a high source; debug clock code 1h reuses slot 0
            exp_out = (cd == 4'h1 && rows[i][5:1] != 5'h17) || cd == 4'h4;
            if (rows[i][0])
                `CHK("pin_out", exp_out, pin_out[rows[i][5:1]])
        end
        // a bidirectional slot follows the peripheral's own drive request
        @(posedge core_clk);
        periph_oe <= {120{1'b0}};
        wr(OFF_SEL17, 32'h0400_0000);
        rd(OFF_SEL17, 0);
        #1;
        `CHK("bidir released", 1'b0, pin_oe[6])
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        `CHK("idle after reset", 5'b11100, {awready, wready, arready, bvalid, rvalid})
        rd(OFF_SEL18, 0);
        `CHK("second reset", SEL_RESET, q)
        #1;
        `CHK("debug clock after reset", 1'b1, pin_oe[23])
        `CHK("pin released after reset", 1'b0, pin_oe[16])
        @(posedge core_clk);
        wstrb <= 4'h1;
        wr(OFF_SEL18, 32'hffff_ffff);
        wstrb <= 4'hf;
        rd(OFF_SEL18, 0);
        `CHK("byte lane write", 32'h0000_00ff, q)
        give_verdict;
    end
endmodule : testbench
